// File: core/bmt_pkg.sv
package bmt_pkg;

    localparam int CLK_MHZ = 125;
    localparam int TW = 17;

    // Times in ns
    localparam int START_NS = 2500;
    localparam int GAP_NS = 9500;
    localparam int TO_0_NS = 18500;
    localparam int TO_1_NS = 22500;
    localparam int TO_2_NS = 50500;
    localparam int TO_3_NS = 128000;
    localparam int RT_MIN_NS = 4000;
    localparam int RT_MAX_NS = 7000;
    localparam int WDOG_NS = 660500;

    localparam logic [TW-1:0] START_CYC =
        TW'((START_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] GAP_CYC = TW'((GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TO_0_CYC = TW'((TO_0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TO_1_CYC = TW'((TO_1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TO_2_CYC = TW'((TO_2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] TO_3_CYC = TW'((TO_3_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] RT_RESP_CYC =
        TW'(((RT_MIN_NS + RT_MAX_NS) / 2 * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] WDOG_CYC =
        TW'((WDOG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [6:0] US_DIV = 7'(CLK_MHZ - 1);

    localparam logic [TW-1:0] ENH_GAP_CYC = 17'h0000a;
    localparam logic [7:0] STRETCH_CYC = 8'h06;
    localparam logic [2:0] SOM_XFERS = 3'h7;
    localparam logic [2:0] EOM_XFERS = 3'h5;

    // APB offsets
    localparam logic [18:0] OFF_CTRL = 19'h00000;
    localparam logic [18:0] OFF_CMD = 19'h00004;
    localparam logic [18:0] OFF_GAPX = 19'h00008;
    localparam logic [18:0] OFF_MCNT = 19'h0000c;
    localparam logic [18:0] OFF_STAT = 19'h00010;
    localparam logic [18:0] OFF_MASK = 19'h00014;
    localparam logic [18:0] OFF_STATE = 19'h00018;
    localparam int RAM_SEL_BIT = 18;

    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;

    // Status bits
    localparam int ST_TIMEOUT = 0;
    localparam int ST_WDOG = 1;
    localparam int ST_PERR = 2;
    localparam int ST_MSGDONE = 3;
    localparam int ST_RTSTAT = 4;
    localparam int ST_W = 5;

    localparam logic [1:0] MODE_BC = 2'h0;
    localparam logic [1:0] MODE_RT = 2'h1;
    localparam logic [1:0] MODE_MT = 2'h2;
    localparam logic [1:0] MODE_RTMT = 2'h3;

    localparam logic [15:0] CTRL_RST = 16'h0000;

    typedef struct packed {
        logic rsvd15;
        logic prio_acc;
        logic [4:0] rsvd;
        logic retry_en;
        logic [1:0] to_sel;
        logic [1:0] proto;
        logic bus_b;
        logic enh;
        logic [1:0] mode;
    } bmt_ctrl_t;

    typedef enum logic [2:0] {
        BC_IDLE = 3'b000,
        BC_START = 3'b001,
        BC_SOM = 3'b010,
        BC_MSG = 3'b011,
        BC_EOM = 3'b100,
        BC_GAP = 3'b101,
        BC_GAPX = 3'b110
    } bmt_bc_st_t;

endpackage

// File: core/bmt_timer.sv
`timescale 1ns/1ps
module bmt_timer
    import bmt_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic [TW-1:0] cnt_in,
    input wire logic stop_in,
    output logic busy_out,
    output logic expire_out
);
    logic [TW-1:0] cnt_ff;
    logic [TW-1:0] nxt_cnt;
    logic exp_ff;
    logic nxt_exp;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = 1'b0;
        if (load_in) begin
            nxt_cnt = cnt_in;
        end else if (stop_in) begin
            nxt_cnt = '0;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - TW'(1);
            nxt_exp = (cnt_ff == TW'(1));
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign busy_out = (cnt_ff != '0);
    assign expire_out = exp_ff;
endmodule

// File: core/bmt_ram.sv
`timescale 1ns/1ps
module bmt_ram (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic we_in,
    input wire logic re_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic perr_out
);
    logic [16:0] mem [0:65535];
    logic [16:0] rd_ff;
    logic rv_ff;

    // Bit 16 holds parity
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= {^wdata_in, wdata_in};
        end
        if (re_in) begin
            rd_ff <= mem[addr_in];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rv_ff <= 1'b0;
        end else begin
            rv_ff <= re_in;
        end
    end

    assign rdata_out = rd_ff[15:0];
    assign perr_out = rv_ff & (rd_ff[16] != ^rd_ff[15:0]);
endmodule

// File: core/bmt_core.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
// What this block does
// [R1] Channel mode chosen independently: BC, RT, MT, RT/MT
// [R2] Either bus of redundant pair selectable
// [R3] One engine serves 1553A, 1553B, STANAG variants
// [R4] Shared 64K word RAM parity checked on read
// [R5] Legacy BC first message 2.5 us after start
// [R6] Minimum gap 9.5 us, enhanced 9.58 us (1198 clocks)
// [R7] Enhanced gap ten clocks longer than legacy
// [R8] Software lengthens gap in 1 us steps
// [R9] Priority access: host access in sequence adds 6
// [R10] Start sequence 7 transfers, end sequence 5
// [R11] Response timeout selectable 18.5/22.5/50.5/128 us
// [R12] RT-to-RT timeout mid-parity to mid-sync
// [R13] RT status starts 4 to 7 us after command
// [R14] Watchdog stops transmission beyond 660.5 us
// [R15] Enhanced BC sequences messages, retries, switches bus
// [R16] Two-bit timeout field, expiry flagged to host
module bmt_core
    import bmt_pkg::*;
#(
    parameter logic [TW-1:0] TO_2_LEN = TO_2_CYC,
    parameter logic [TW-1:0] TO_3_LEN = TO_3_CYC,
    parameter logic [TW-1:0] WDOG_LEN = WDOG_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [18:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic cmd_mid_parity_in,
    input wire logic stat_mid_sync_in,
    input wire logic msg_done_in,
    input wire logic tx_active_in,
    output logic msg_start_out,
    output logic status_start_out,
    output logic bus_b_out,
    output logic [1:0] mode_out,
    output logic [1:0] proto_out,
    output logic tx_inhibit_out,
    output logic irq_out
);
    bmt_ctrl_t ctrl_ff, nxt_ctrl;
    logic [15:0] gapx_ff, nxt_gapx;
    logic [15:0] mcnt_ff, nxt_mcnt;
    logic [ST_W-1:0] stat_ff, nxt_stat;
    logic [ST_W-1:0] mask_ff, nxt_mask;
    logic [31:0] prd_ff, nxt_prd;
    logic irq_ff, nxt_irq;
    logic slverr;

    bmt_bc_st_t st_ff, nxt_st;
    logic [2:0] idx_ff, nxt_idx;
    logic [7:0] str_ff, nxt_str;
    logic [15:0] rem_ff, nxt_rem;
    logic [15:0] usc_ff, nxt_usc;
    logic retried_ff, nxt_retried;
    logic bus_b_ff, nxt_bus_b;
    logic start_ff, nxt_start;
    logic [6:0] div_ff, nxt_div;
    logic us_tick;
    logic stat_go_ff, nxt_stat_go;
    logic inh_ff, nxt_inh;
    logic txa_d_ff;

    logic seq_load;
    logic [TW-1:0] seq_cnt;
    logic seq_exp;
    logic to_load;
    logic [TW-1:0] to_cnt;
    logic to_busy;
    logic to_exp;
    logic rt_exp;
    logic wd_exp;

    logic setup, access, ram_sel, reg_wr, host_acc;
    logic [15:0] ram_rd;
    logic perr;

    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign ram_sel = paddr_in[RAM_SEL_BIT];
    assign reg_wr = access & pwrite_in & ~ram_sel;
    assign host_acc = access & ram_sel;
    assign us_tick = (div_ff == US_DIV);

    // Host RAM port
    bmt_ram u_ram (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .we_in(access & pwrite_in & ram_sel),
        .re_in(setup & ~pwrite_in & ram_sel),
        .addr_in(paddr_in[17:2]),
        .wdata_in(pwdata_in[15:0]),
        .rdata_out(ram_rd),
        .perr_out(perr)
    ); // [R4]

    bmt_timer u_seq (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .load_in(seq_load),
        .cnt_in(seq_cnt),
        .stop_in(1'b0),
        .busy_out(),
        .expire_out(seq_exp)
    );

    bmt_timer u_resp_to (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .load_in(to_load),
        .cnt_in(to_cnt),
        .stop_in(stat_mid_sync_in),
        .busy_out(to_busy),
        .expire_out(to_exp)
    ); // [R12]

    bmt_timer u_rt_resp (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .load_in(cmd_mid_parity_in & ctrl_ff.mode[0]),
        .cnt_in(RT_RESP_CYC),
        .stop_in(1'b0),
        .busy_out(),
        .expire_out(rt_exp)
    ); // [R13]

    bmt_timer u_wdog (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .load_in(tx_active_in & ~txa_d_ff),
        .cnt_in(WDOG_LEN),
        .stop_in(~tx_active_in),
        .busy_out(),
        .expire_out(wd_exp)
    ); // [R14]

    // Timeout select
    always_comb begin
        to_load = cmd_mid_parity_in; // [R12]
        unique case (ctrl_ff.to_sel) // [R11] [R16]
            2'h0: to_cnt = TO_0_CYC;
            2'h1: to_cnt = TO_1_CYC;
            2'h2: to_cnt = TO_2_LEN;
            2'h3: to_cnt = TO_3_LEN;
        endcase
    end

    // Bus controller sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_str = str_ff;
        nxt_rem = rem_ff;
        nxt_usc = usc_ff;
        nxt_retried = retried_ff;
        nxt_bus_b = bus_b_ff;
        nxt_start = 1'b0;
        seq_load = 1'b0;
        seq_cnt = START_CYC;
        if ((st_ff == BC_SOM || st_ff == BC_EOM) && host_acc
                && ctrl_ff.prio_acc) begin
            nxt_str = str_ff + STRETCH_CYC; // [R9]
        end
        unique case (st_ff)
            BC_IDLE: begin
                nxt_bus_b = ctrl_ff.bus_b; // [R2]
                if (reg_wr && paddr_in == OFF_CMD && pwdata_in[CMD_START]
                        && ctrl_ff.mode == MODE_BC) begin
                    seq_load = 1'b1; // [R5]
                    nxt_rem = mcnt_ff;
                    nxt_str = '0;
                    nxt_st = ctrl_ff.enh ? BC_SOM : BC_START;
                    nxt_idx = '0;
                end
            end
            BC_START: begin
                if (seq_exp) begin
                    nxt_st = BC_SOM; // [R5]
                    nxt_idx = '0;
                end
            end
            BC_SOM: begin
                nxt_idx = idx_ff + 3'h1;
                if (idx_ff == SOM_XFERS - 3'h1) begin
                    nxt_st = BC_MSG; // [R10]
                    nxt_start = 1'b1;
                    nxt_retried = 1'b0;
                end
            end
            BC_MSG: begin
                if (msg_done_in) begin
                    nxt_st = BC_EOM;
                    nxt_idx = '0;
                end else if (to_exp && ctrl_ff.enh && ctrl_ff.retry_en
                        && !retried_ff) begin
                    nxt_retried = 1'b1; // [R15]
                    nxt_bus_b = ~bus_b_ff;
                    nxt_start = 1'b1;
                end
            end
            BC_EOM: begin
                nxt_idx = idx_ff + 3'h1;
                if (idx_ff == EOM_XFERS - 3'h1) begin
                    nxt_st = BC_GAP; // [R10]
                    seq_load = 1'b1;
                end
                seq_cnt = GAP_CYC + (ctrl_ff.enh ? ENH_GAP_CYC : '0)
                    + TW'(nxt_str); // [R6] [R7] [R9]
            end
            BC_GAP: begin
                if (seq_exp) begin
                    nxt_str = '0;
                    nxt_usc = gapx_ff;
                    nxt_st = BC_GAPX; // [R8]
                end
            end
            BC_GAPX: begin
                if (usc_ff != '0) begin
                    if (us_tick) begin
                        nxt_usc = usc_ff - 16'h0001; // [R8]
                    end
                end else if (ctrl_ff.enh && rem_ff > 16'h0001) begin
                    nxt_rem = rem_ff - 16'h0001; // [R15]
                    nxt_st = BC_SOM;
                    nxt_idx = '0;
                    nxt_bus_b = ctrl_ff.bus_b;
                end else begin
                    nxt_st = BC_IDLE;
                end
            end
            default: nxt_st = BC_IDLE;
        endcase
        if (reg_wr && paddr_in == OFF_CMD && pwdata_in[CMD_STOP]) begin
            nxt_st = BC_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            st_ff <= BC_IDLE;
            idx_ff <= '0;
            str_ff <= '0;
            rem_ff <= '0;
            usc_ff <= '0;
            retried_ff <= 1'b0;
            bus_b_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            str_ff <= nxt_str;
            rem_ff <= nxt_rem;
            usc_ff <= nxt_usc;
            retried_ff <= nxt_retried;
            bus_b_ff <= nxt_bus_b;
            start_ff <= nxt_start;
        end
    end

    // Tick, RT status and watchdog
    always_comb begin
        nxt_div = us_tick ? 7'h00 : div_ff + 7'h01;
        if (st_ff != BC_GAPX) begin
            nxt_div = 7'h00;
        end
        nxt_stat_go = rt_exp; // [R13]
        nxt_inh = inh_ff;
        if (wd_exp) begin
            nxt_inh = 1'b1; // [R14]
        end else if (!tx_active_in) begin
            nxt_inh = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            div_ff <= '0;
            stat_go_ff <= 1'b0;
            inh_ff <= 1'b0;
            txa_d_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            stat_go_ff <= nxt_stat_go;
            inh_ff <= nxt_inh;
            txa_d_ff <= tx_active_in;
        end
    end

    // Registers
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_gapx = gapx_ff;
        nxt_mcnt = mcnt_ff;
        nxt_mask = mask_ff;
        nxt_prd = prd_ff;
        nxt_stat = stat_ff;
        slverr = 1'b0;
        if (!ram_sel) begin
            unique case (paddr_in)
                OFF_CTRL, OFF_CMD, OFF_GAPX, OFF_MCNT, OFF_STAT, OFF_MASK,
                OFF_STATE: slverr = 1'b0;
                default: slverr = 1'b1;
            endcase
        end
        if (setup && !ram_sel) begin
            nxt_prd = '0;
            unique case (paddr_in)
                OFF_CTRL: nxt_prd = {16'h0000, ctrl_ff};
                OFF_GAPX: nxt_prd = {16'h0000, gapx_ff};
                OFF_MCNT: nxt_prd = {16'h0000, mcnt_ff};
                OFF_STAT: nxt_prd = 32'(stat_ff);
                OFF_MASK: nxt_prd = 32'(mask_ff);
                OFF_STATE: nxt_prd = {rem_ff, str_ff, 2'h0, inh_ff,
                    to_busy, bus_b_ff, st_ff};
                default: nxt_prd = '0;
            endcase
        end
        if (reg_wr) begin
            unique case (paddr_in)
                OFF_CTRL: nxt_ctrl = bmt_ctrl_t'(pwdata_in[15:0]); // [R1] [R3]
                OFF_GAPX: nxt_gapx = pwdata_in[15:0]; // [R8]
                OFF_MCNT: nxt_mcnt = pwdata_in[15:0];
                OFF_MASK: nxt_mask = pwdata_in[ST_W-1:0];
                default: nxt_mcnt = mcnt_ff;
            endcase
        end
        if (access && !pwrite_in && !ram_sel && paddr_in == OFF_STAT) begin
            nxt_stat = stat_ff & ~prd_ff[ST_W-1:0];
        end
        // New events win over the read clear
        nxt_stat[ST_TIMEOUT] = nxt_stat[ST_TIMEOUT] | to_exp; // [R16]
        nxt_stat[ST_WDOG] = nxt_stat[ST_WDOG] | wd_exp; // [R14]
        nxt_stat[ST_PERR] = nxt_stat[ST_PERR] | perr; // [R4]
        nxt_stat[ST_MSGDONE] = nxt_stat[ST_MSGDONE] | msg_done_in;
        nxt_stat[ST_RTSTAT] = nxt_stat[ST_RTSTAT] | rt_exp;
        nxt_irq = |(nxt_stat & mask_ff);
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctrl_ff <= bmt_ctrl_t'(CTRL_RST);
            gapx_ff <= '0;
            mcnt_ff <= '0;
            mask_ff <= '0;
            stat_ff <= '0;
            prd_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            gapx_ff <= nxt_gapx;
            mcnt_ff <= nxt_mcnt;
            mask_ff <= nxt_mask;
            stat_ff <= nxt_stat;
            prd_ff <= nxt_prd;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata_out = ram_sel ? {16'h0000, ram_rd} : prd_ff;
    assign pready_out = 1'b1;
    assign pslverr_out = access & slverr;
    assign msg_start_out = start_ff;
    assign status_start_out = stat_go_ff;
    assign bus_b_out = bus_b_ff;
    assign mode_out = ctrl_ff.mode; // [R1]
    assign proto_out = ctrl_ff.proto; // [R3]
    assign tx_inhibit_out = inh_ff;
    assign irq_out = irq_ff;
endmodule

// File: verif/bmt_core_sva.sv
`timescale 1ns/1ps
module bmt_core_sva
    import bmt_pkg::*;
#(
    parameter logic [TW-1:0] WDOG_LEN = WDOG_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [18:0] paddr_in,
    input wire logic cmd_mid_parity_in,
    input wire logic msg_done_in,
    input wire logic tx_active_in,
    input wire logic msg_start_out,
    input wire logic status_start_out,
    input wire logic [1:0] mode_out,
    input wire logic [1:0] proto_out,
    input wire logic tx_inhibit_out
);
    logic [11:0] rt_cnt_ff, nxt_rt_cnt, gap_cnt_ff, nxt_gap_cnt;
    logic [TW-1:0] tx_cnt_ff, nxt_tx_cnt;
    logic ctrl_wr;

    // Event age counters
    always_comb begin
        ctrl_wr = psel_in && penable_in && pwrite_in && paddr_in == OFF_CTRL;
        nxt_rt_cnt = cmd_mid_parity_in ? 12'h001 :
            rt_cnt_ff + {11'h000, rt_cnt_ff != 12'hfff};
        nxt_gap_cnt = msg_done_in ? 12'h001 :
            gap_cnt_ff + {11'h000, gap_cnt_ff != 12'hfff};
        nxt_tx_cnt = tx_active_in ? tx_cnt_ff + 17'h00001 : 17'h00000;
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            rt_cnt_ff <= 12'hfff;
            gap_cnt_ff <= 12'hfff;
            tx_cnt_ff <= 17'h00000;
        end else begin
            rt_cnt_ff <= nxt_rt_cnt;
            gap_cnt_ff <= nxt_gap_cnt;
            tx_cnt_ff <= nxt_tx_cnt;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    property p_msg_pulse;
        msg_start_out |=> !msg_start_out;
    endproperty
    a_msg_pulse: assert property (p_msg_pulse)
        else $error("start too wide");

    property p_bc_only;
        msg_start_out |-> mode_out == MODE_BC;
    endproperty
    a_bc_only: assert property (p_bc_only)
        else $error("start not in BC");

    property p_gap;
        msg_start_out |-> gap_cnt_ff >= 12'h4a9;
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap short");

    property p_rt_win;
        status_start_out |-> rt_cnt_ff >= 12'h1f4 && rt_cnt_ff <= 12'h36b;
    endproperty
    a_rt_win: assert property (p_rt_win)
        else $error("status out of window");

    property p_rt_mode;
        status_start_out |-> mode_out[0];
    endproperty
    a_rt_mode: assert property (p_rt_mode)
        else $error("status not in RT");

    property p_cfg_stable;
        !ctrl_wr && !$past(ctrl_wr) |=> $stable(mode_out) && $stable(proto_out);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable)
        else $error("config changed");

    property p_wdog_min;
        $rose(tx_inhibit_out) |-> tx_cnt_ff + 17'h00002 >= WDOG_LEN;
    endproperty
    a_wdog_min: assert property (p_wdog_min)
        else $error("wdog early");

    property p_wdog_max;
        tx_cnt_ff == WDOG_LEN + 17'h00005 |-> tx_inhibit_out;
    endproperty
    a_wdog_max: assert property (p_wdog_max)
        else $error("wdog late");

    property p_inh_hold;
        tx_inhibit_out && tx_active_in |=> tx_inhibit_out;
    endproperty
    a_inh_hold: assert property (p_inh_hold)
        else $error("inhibit dropped");
endmodule

// File: verif/bmt_far_end.sv
`timescale 1ns/1ps
module bmt_far_end (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic msg_start_in,
    input wire logic no_resp_in,
    input wire logic cmd_req_in,
    input wire logic hold_tx_in,
    output logic cmd_mid_parity_out,
    output logic stat_mid_sync_out,
    output logic msg_done_out,
    output logic tx_active_out
);
    // Message phase counter
    logic [11:0] ph_ff;
    logic [11:0] last;
    logic run;
    assign last = no_resp_in ? 12'hc00 : 12'h300;
    assign run = ph_ff != 12'h000 && ph_ff != last;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ph_ff <= 12'h000;
            cmd_mid_parity_out <= 1'b0;
            stat_mid_sync_out <= 1'b0;
            msg_done_out <= 1'b0;
            tx_active_out <= 1'b0;
        end else begin
            ph_ff <= msg_start_in ? 12'h001 : run ? ph_ff + 12'h001 : 12'h000;
            cmd_mid_parity_out <= cmd_req_in || ph_ff == 12'h014;
            stat_mid_sync_out <= !no_resp_in && ph_ff == 12'h2d0;
            msg_done_out <= ph_ff == last;
            tx_active_out <= hold_tx_in || (run && ph_ff < 12'h014);
        end
    end
endmodule

// File: verif/bmt_core_tb_top.sv
`timescale 1ns/1ps
module bmt_core_tb_top;
    import bmt_pkg::*;
    localparam logic [TW-1:0] TO2 = 17'h00032;
    localparam logic [TW-1:0] TO3 = 17'h00050;
    localparam logic [TW-1:0] WDL = 17'h00064;
    logic mclk_in = 1'b0, resetn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic no_resp = 1'b0, cmd_req = 1'b0, hold_tx = 1'b0;
    logic [18:0] paddr = 19'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, er_v, cmp, sms, mdone, txa;
    logic msg_start, st_start, bus_b, inh, irq;
    logic [1:0] mode, proto;
    logic [4:0] ev;
    int failures = 0, n_tests = 0, cyc = 0;
    assign ev = {irq, inh, mdone, st_start, msg_start};

    bmt_core #(.TO_2_LEN(TO2), .TO_3_LEN(TO3), .WDOG_LEN(WDL)) bmt_core_inst (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cmd_mid_parity_in(cmp),
        .stat_mid_sync_in(sms), .msg_done_in(mdone), .tx_active_in(txa),
        .msg_start_out(msg_start), .status_start_out(st_start),
        .bus_b_out(bus_b), .mode_out(mode), .proto_out(proto),
        .tx_inhibit_out(inh), .irq_out(irq));

    bmt_far_end bmt_far_end_inst (
        .clk_in(mclk_in), .resetn_in(resetn_in), .msg_start_in(msg_start),
        .no_resp_in(no_resp), .cmd_req_in(cmd_req), .hold_tx_in(hold_tx),
        .cmd_mid_parity_out(cmp), .stat_mid_sync_out(sms),
        .msg_done_out(mdone), .tx_active_out(txa));

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    task give_verdict();
        $display("Checks %0d, errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            give_verdict();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [18:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_in);
    endtask

    task wt(input int k, output int n);
        n = 0;
        while (ev[k] !== 1'b1 && n < 4000) begin
            @(posedge mclk_in);
            n++;
        end
    endtask

    task t_regs();
        int i;
        apb(1'b0, 19'h0001c, 32'h0);
        chk({er_v, rd_v[30:0]}, 32'h80000000);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CTRL, 32'(i | i << 4 | (i & 1) << 3));
            @(posedge mclk_in);
            chk(32'({bus_b, proto, mode}), 32'((i & 1) << 4 | i << 2 | i));
        end
        apb(1'b1, OFF_MASK, 32'h1f);
        apb(1'b0, OFF_MASK, 32'h0);
        chk(rd_v, 32'h1f);
        $display("regs done");
    endtask

    task t_ram();
        int i;
        logic [18:0] a;
        for (i = 0; i < 2; i++) begin
            a = i ? 19'h7fffc : 19'h40014;
            apb(1'b1, a, 32'hffff0000 | 32'(16'h5a3c ^ i));
            apb(1'b0, a, 32'h0);
            chk(rd_v, 32'(16'h5a3c ^ i));
        end
        apb(1'b0, OFF_STAT, 32'h0);
        chk(32'(rd_v[ST_PERR]), 32'h0);
        $display("ram done");
    endtask

    task t_legacy();
        int n;
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_CMD, 32'h1);
        wt(0, n);
        chk(32'(n >= 311 && n <= 330), 32'h1);
        wt(2, n);
        repeat (1300) @(posedge mclk_in);
        $display("start done");
    endtask

    task t_gap();
        int i, n, e;
        for (i = 0; i < 3; i++) begin
            apb(1'b1, OFF_CTRL, i == 2 ? 32'h4004 : 32'h4);
            apb(1'b1, OFF_GAPX, 32'(i == 1));
            apb(1'b1, OFF_MCNT, 32'h2);
            apb(1'b1, OFF_CMD, 32'h1);
            wt(0, n);
            wt(2, n);
            e = 1213 + 125 * (i == 1) + 6 * (i == 2);
            if (i == 2) begin
                apb(1'b0, 19'h40000, 32'h0);
            end
            wt(0, n);
            n += 3 * (i == 2);
            chk(32'(n >= e - 2 && n <= e + 8), 32'h1);
            wt(2, n);
            apb(1'b1, OFF_CMD, 32'h2);
            repeat (1300) @(posedge mclk_in);
        end
        $display("gap test done");
    endtask

    task t_tmo();
        int i, n, e;
        no_resp <= 1'b1;
        apb(1'b1, OFF_MASK, 32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CTRL, 32'(i << 6));
            apb(1'b1, OFF_CMD, 32'h1);
            wt(0, n);
            wt(4, n);
            e = i == 0 ? 2313 : i == 1 ? 2813 : i == 2 ? 50 : 80;
            chk(32'(n >= e + 18 && n <= e + 26), 32'h1);
            apb(1'b1, OFF_MASK, 32'h0);
            @(posedge mclk_in);
            chk(32'(irq), 32'h0);
            apb(1'b1, OFF_MASK, 32'h1);
            @(posedge mclk_in);
            chk(32'(irq), 32'h1);
            apb(1'b0, OFF_STAT, 32'h0);
            chk(32'(rd_v[ST_TIMEOUT]), 32'h1);
            @(posedge mclk_in);
            chk(32'(irq), 32'h0);
            wt(2, n);
            repeat (1300) @(posedge mclk_in);
        end
        no_resp <= 1'b0;
        $display("tmo done");
    endtask

    task t_rt();
        int i, n;
        for (i = 1; i < 4; i += 2) begin
            apb(1'b1, OFF_CTRL, 32'(i));
            cmd_req <= 1'b1;
            @(posedge mclk_in);
            cmd_req <= 1'b0;
            wt(1, n);
            chk(32'(n >= 501 && n <= 876), 32'h1);
        end
        $display("rt done");
    endtask

    task t_wdog();
        int n;
        hold_tx <= 1'b1;
        wt(3, n);
        chk(32'(n >= 98 && n <= 108), 32'h1);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(32'(rd_v[ST_WDOG]), 32'h1);
        hold_tx <= 1'b0;
        repeat (4) @(posedge mclk_in);
        chk(32'(inh), 32'h0);
        $display("wdog done");
    endtask

    initial begin
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        t_regs();
        t_ram();
        t_legacy();
        t_gap();
        t_tmo();
        t_rt();
        t_wdog();
        give_verdict();
    end
endmodule

bind bmt_core bmt_core_sva #(.WDOG_LEN(WDOG_LEN)) bmt_core_sva_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .cmd_mid_parity_in(cmd_mid_parity_in), .msg_done_in(msg_done_in),
    .tx_active_in(tx_active_in), .msg_start_out(msg_start_out),
    .status_start_out(status_start_out), .mode_out(mode_out),
    .proto_out(proto_out), .tx_inhibit_out(tx_inhibit_out));
